/* rtl/fsw_defines.vh */
// Opcodes, status bit positions, table bytes and timing counts.
`ifndef FSW_DEFINES_VH
`define FSW_DEFINES_VH

// ============================================================
// Instruction opcodes
// ============================================================
`define FSW_OP_STATUS_WRITE 8'h01
`define FSW_OP_PROG 8'h02
`define FSW_OP_LATCH_CLR 8'h04
`define FSW_OP_RDSR 8'h05
`define FSW_OP_LATCH_SET 8'h06
`define FSW_OP_ERASE 8'h20
`define FSW_OP_RDFR 8'h48
`define FSW_OP_SFDP 8'h5a
`define FSW_OP_RSTEN 8'h66
`define FSW_OP_SUSP 8'h75
`define FSW_OP_RESUME 8'h7a
`define FSW_OP_RDERP 8'h81
`define FSW_OP_RST 8'h99

// ============================================================
// Status register bit positions and reset value
// ============================================================
`define FSW_BIT_BUSY 0
`define FSW_BIT_LATCH 1
`define FSW_BIT_BP_LO 2
`define FSW_BIT_BP_HI 5
`define FSW_BIT_QUAD 6
`define FSW_BIT_LOCK 7
`define FSW_STATUS_RST 8'h00

// ============================================================
// Byte counts of complete instructions
// ============================================================
`define FSW_NB_SHORT 3'd1
`define FSW_NB_STATUS_WRITE 3'd2
`define FSW_NB_ERASE 3'd4
`define FSW_NB_PROG 3'd5
`define FSW_NB_SFDP_A 3'd4
`define FSW_NB_SFDP_D 3'd5

// ============================================================
// Parameter table bytes, held at byte addresses 64h to 6bh
// ============================================================
`define FSW_TBL_BASE 8'h64
`define FSW_TBL_64 8'hf7
`define FSW_TBL_65 8'ha2
`define FSW_TBL_66 8'hd5
`define FSW_TBL_67 8'h5c
`define FSW_TBL_68 8'h4a
`define FSW_TBL_69 8'hc2
`define FSW_TBL_6A 8'h2c
`define FSW_TBL_6B 8'hff
`define FSW_TBL_BLANK 8'hff

// ============================================================
// Timing
// ============================================================
`define FSW_BUSY_CYCLES 1000

`endif

/* rtl/fsw_param_rom.v */
// Parameter table memory with a registered read port.
`timescale 1ns/1ns
`default_nettype none
`include "fsw_defines.vh"

module fsw_param_rom (
  input wire clk,
  input wire [7:0] addr,
  output reg [7:0] rdata
);

  // ============================================================
  // Table lookup
  // ============================================================
  // Read data is registered so the serial side always sees a settled byte.
  always @(posedge clk) begin
    case (addr)
      8'h64: rdata <= `FSW_TBL_64;
      8'h65: rdata <= `FSW_TBL_65; // Exit code in bits 22:15.
      8'h66: rdata <= `FSW_TBL_66; // Entry code in bits 30:23.
      8'h67: rdata <= `FSW_TBL_67;
      8'h68: rdata <= `FSW_TBL_68; // Quad leave 1010b, entry 00100b.
      8'h69: rdata <= `FSW_TBL_69;
      8'h6a: rdata <= `FSW_TBL_6A;
      8'h6b: rdata <= `FSW_TBL_6B;
      default: rdata <= `FSW_TBL_BLANK;
    endcase
  end

endmodule // fsw_param_rom
`default_nettype wire

/* rtl/fsw_status_bank.v */
// Status register, write latch and busy logic behind the serial pins.
`timescale 1ns/1ns
`default_nettype none
`include "fsw_defines.vh"

module fsw_status_bank #(
  parameter BUSY_CYCLES = `FSW_BUSY_CYCLES
) (
  input wire CORE_CLK,
  input wire SRST,
  input wire SCK,
  input wire CE_N,
  input wire SI,
  output reg SO,
  output reg SO_OE,
  output reg [7:0] STATUS,
  output reg QUAD_EN,
  output reg BUSY
);

  localparam ST_LOAD = 1'b0;
  localparam ST_RUN = 1'b1;
  localparam [1:0] K_STATUS = 2'd0;
  localparam [1:0] K_PROG = 2'd1;
  localparam [1:0] K_ERASE = 2'd2;

  // ============================================================
  // Pin synchronisers
  // ============================================================
  reg sck_s1_r, sck_s2_r, sck_d_r;
  reg ce_s1_r, ce_s2_r, ce_d_r;
  reg si_s1_r, si_s2_r;

  // The serial clock is sampled, so it must stay well below a quarter
  // of the core rate; 160 ns against 8 ns leaves ample margin.
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_d_r <= 1'b0;
      ce_s1_r <= 1'b1;
      ce_s2_r <= 1'b1;
      ce_d_r <= 1'b1;
      si_s1_r <= 1'b0;
      si_s2_r <= 1'b0;
    end else begin
      sck_s1_r <= SCK;
      sck_s2_r <= sck_s1_r;
      sck_d_r <= sck_s2_r;
      ce_s1_r <= CE_N;
      ce_s2_r <= ce_s1_r;
      ce_d_r <= ce_s2_r;
      si_s1_r <= SI;
      si_s2_r <= si_s1_r;
    end
  end

  wire sel = ~ce_s2_r;
  wire sck_rise = sel & sck_s2_r & ~sck_d_r;
  wire sck_fall = sel & ~sck_s2_r & sck_d_r;
  wire ce_end = ce_s2_r & ~ce_d_r;

  // ============================================================
  // State
  // ============================================================
  reg st_r;
  reg [5:0] nv_r; // Non-volatile lock, quad and protect cells.
  reg [5:0] vol_r; // Working copy that the logic obeys.
  reg latch_r, busy_r, susp_r, rst_en_r;
  reg [1:0] kind_r;
  reg [15:0] tmr_r;
  reg [2:0] bitn_r, nbyte_r;
  reg [7:0] sh_r, op_r, data_r, out_r, rom_a_r;
  reg rd_r;
  wire [7:0] rom_q;
  wire [7:0] byte_in = {sh_r[6:0], si_s2_r};
  wire [7:0] status = {vol_r, latch_r, busy_r};

  // Instructions that a running operation lets through.
  function allowed_busy;
    input [7:0] op;
    begin
      allowed_busy = (op == `FSW_OP_RDSR) || (op == `FSW_OP_RDFR) ||
        (op == `FSW_OP_RDERP) || (op == `FSW_OP_SUSP) ||
        (op == `FSW_OP_RSTEN) || (op == `FSW_OP_RST);
    end
  endfunction

  fsw_param_rom u_rom (
    .clk(CORE_CLK),
    .addr(rom_a_r),
    .rdata(rom_q)
  );

  // ============================================================
  // Serial shifter and read data path
  // ============================================================
  // Bytes are counted up to seven and then held, which is enough to
  // tell every instruction length apart without a wide counter.
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      bitn_r <= 3'd0;
      nbyte_r <= 3'd0;
      sh_r <= 8'h00;
      op_r <= 8'h00;
      data_r <= 8'h00;
      out_r <= 8'h00;
      rom_a_r <= 8'h00;
      rd_r <= 1'b0;
      SO <= 1'b0;
      SO_OE <= 1'b0;
    end else if (!sel) begin
      bitn_r <= 3'd0;
      nbyte_r <= 3'd0;
      rd_r <= 1'b0;
      SO_OE <= 1'b0;
    end else if (sck_rise) begin
      sh_r <= byte_in;
      bitn_r <= bitn_r + 3'd1;
      if (bitn_r == 3'd7) begin
        if (nbyte_r != 3'd7)
          nbyte_r <= nbyte_r + 3'd1;
        if (nbyte_r == 3'd0)
          op_r <= byte_in;
        if (nbyte_r == 3'd1)
          data_r <= byte_in;
        // A status read reloads the status register every byte until deselect.
        if ((nbyte_r == 3'd0 && byte_in == `FSW_OP_RDSR) ||
            (nbyte_r != 3'd0 && op_r == `FSW_OP_RDSR)) begin
          out_r <= status;
          rd_r <= 1'b1;
        end else if ((nbyte_r == 3'd0) && ((byte_in == `FSW_OP_RDFR) ||
                     (byte_in == `FSW_OP_RDERP))) begin
          out_r <= 8'h00;
          rd_r <= 1'b1;
        end else if (op_r == `FSW_OP_SFDP && !busy_r) begin
          if (nbyte_r == `FSW_NB_SFDP_A - 3'd1)
            rom_a_r <= byte_in;
          if (nbyte_r >= `FSW_NB_SFDP_D - 3'd1) begin
            out_r <= rom_q;
            rom_a_r <= rom_a_r + 8'h01;
            rd_r <= (nbyte_r >= `FSW_NB_SFDP_D);
          end
        end
      end
    end else if (sck_fall) begin
      SO_OE <= rd_r;
      SO <= out_r[7];
      out_r <= {out_r[6:0], 1'b0};
    end
  end

  // ============================================================
  // Instruction execution and busy timer
  // ============================================================
  // Instructions act when chip enable rises on a byte boundary, so a
  // deselect in mid-byte discards the instruction.
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      st_r <= ST_LOAD;
      nv_r <= 6'h00;
      vol_r <= 6'h00;
      latch_r <= 1'b0;
      busy_r <= 1'b0;
      susp_r <= 1'b0;
      rst_en_r <= 1'b0;
      kind_r <= K_STATUS;
      tmr_r <= 16'h0000;
    end else if (st_r == ST_LOAD) begin
      vol_r <= nv_r;
      st_r <= ST_RUN;
    end else if (ce_end && bitn_r == 3'd0 && nbyte_r != 3'd0 &&
                 (!busy_r || allowed_busy(op_r))) begin
      rst_en_r <= (op_r == `FSW_OP_RSTEN);
      case (op_r)
        `FSW_OP_LATCH_SET: begin
          if (nbyte_r == `FSW_NB_SHORT)
            latch_r <= 1'b1;
        end
        `FSW_OP_LATCH_CLR: begin
          if (nbyte_r == `FSW_NB_SHORT)
            latch_r <= 1'b0;
        end
        `FSW_OP_STATUS_WRITE: begin
          // The latch bit of the data byte is dropped here.
          if (nbyte_r == `FSW_NB_STATUS_WRITE && latch_r) begin
            nv_r <= data_r[7:2];
            vol_r <= data_r[7:2];
            busy_r <= 1'b1;
            kind_r <= K_STATUS;
            tmr_r <= BUSY_CYCLES[15:0];
          end
        end
        `FSW_OP_PROG, `FSW_OP_ERASE: begin
          if (((op_r == `FSW_OP_PROG && nbyte_r >= `FSW_NB_PROG) ||
               (op_r == `FSW_OP_ERASE && nbyte_r == `FSW_NB_ERASE)) &&
              latch_r && !susp_r &&
              vol_r[`FSW_BIT_BP_HI-2:`FSW_BIT_BP_LO-2] == 4'h0) begin
            busy_r <= 1'b1;
            kind_r <= (op_r == `FSW_OP_PROG) ? K_PROG : K_ERASE;
            tmr_r <= BUSY_CYCLES[15:0];
          end
        end
        `FSW_OP_SUSP: begin
          if (busy_r && kind_r != K_STATUS) begin
            busy_r <= 1'b0;
            susp_r <= 1'b1;
          end
        end
        `FSW_OP_RESUME: begin
          if (susp_r) begin
            busy_r <= 1'b1;
            susp_r <= 1'b0;
          end
        end
        `FSW_OP_RST: begin
          // The reset instruction never acts, as the default branch clears rst_en_r for a reset enable too.
          if (rst_en_r) begin
            busy_r <= 1'b0;
            susp_r <= 1'b0;
            latch_r <= 1'b0;
            tmr_r <= 16'h0000;
          end
        end
        default: begin
          rst_en_r <= 1'b0;
        end
      endcase
    end else if (busy_r) begin
      tmr_r <= tmr_r - 16'h0001;
      if (tmr_r <= 16'h0001) begin
        busy_r <= 1'b0;
        latch_r <= 1'b0;
      end
    end
  end

  // ============================================================
  // Registered outputs
  // ============================================================
  // One cycle behind the internal state, so every output is a flop.
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      STATUS <= `FSW_STATUS_RST;
      QUAD_EN <= 1'b0;
      BUSY <= 1'b0;
    end else begin
      STATUS <= status;
      QUAD_EN <= vol_r[`FSW_BIT_QUAD-2];
      BUSY <= busy_r;
    end
  end

endmodule // fsw_status_bank
`default_nettype wire

/* dv/fsw_status_bank_chk.sv */
// Port checker for the status and write latch block.
`timescale 1ns/1ns
`default_nettype none
module fsw_status_bank_chk #(
  parameter BUSY_CYCLES = 1000
) (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic SCK,
  input wire logic CE_N,
  input wire logic SI,
  input wire logic SO,
  input wire logic SO_OE,
  input wire logic [7:0] STATUS,
  input wire logic QUAD_EN,
  input wire logic BUSY
);
  int busy_run_r;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  // Length of the current busy stretch, to bound it.
  always @(posedge CORE_CLK) begin
    busy_run_r <= (SRST || !BUSY) ? 0 : busy_run_r + 1;
  end
  // A command acts only once select has just risen after a frame.
  sequence s_cmd_end;
    CE_N && !$past(CE_N, 8);
  endsequence
  sequence s_busy_stretch;
    BUSY [*8];
  endsequence
  AST_QUAD_MIRROR: assert property (QUAD_EN == STATUS[6])
    else $error("quad enable differs from status");
  AST_BUSY_MIRROR: assert property (BUSY == STATUS[0])
    else $error("busy differs from status");
  AST_RESET_CLEAR: assert property ($fell(SRST) |->
    STATUS == 8'h00 && !SO_OE) else $error("outputs not clear at reset");
  AST_BUSY_START: assert property ($rose(BUSY) |->
    s_cmd_end ##0 s_busy_stretch) else $error("busy start wrong");
  AST_BUSY_BOUND: assert property (busy_run_r <= BUSY_CYCLES + 4)
    else $error("busy lasts too long");
  AST_LATCH_SET: assert property ($rose(STATUS[1]) |->
    s_cmd_end ##0 !BUSY) else $error("latch set without command");
  AST_LATCH_CLEAR: assert property ($fell(STATUS[1]) |->
    (CE_N && !$past(CE_N, 8)) || $past(BUSY) || $past(BUSY, 2))
    else $error("latch cleared without cause");
  AST_LATCH_AT_END: assert property ($fell(BUSY) && $past(CE_N, 8) |->
    ##[0:1] !STATUS[1]) else $error("latch kept after operation");
  AST_PROT_CHANGE: assert property (!$stable(STATUS[7:2]) |->
    (CE_N && !$past(CE_N, 8)) || $past(SRST) || $past(SRST, 2)
    || $past(SRST, 3)) else $error("status bits changed without cause");
  AST_OE_DESELECT: assert property (CE_N [*8] |-> !SO_OE)
    else $error("output driven while deselected");
endmodule // fsw_status_bank_chk
bind fsw_status_bank fsw_status_bank_chk #(.BUSY_CYCLES(BUSY_CYCLES)) u_chk (
  .CORE_CLK(CORE_CLK), .SRST(SRST), .SCK(SCK), .CE_N(CE_N), .SI(SI),
  .SO(SO), .SO_OE(SO_OE), .STATUS(STATUS), .QUAD_EN(QUAD_EN), .BUSY(BUSY));
`default_nettype wire

/* dv/fsw_host_model.sv */
// Host serial controller model driving clock, select and data in mode 0.
`timescale 1ns/1ns
`default_nettype none
module fsw_host_model (
  input wire logic clk,
  input wire logic so,
  output var logic sck,
  output var logic ce_n,
  output var logic si
);
  // ============================================================
  // Frame driver
  // ============================================================
  // Clock rests low and select high outside frames.
  initial begin
    sck = 1'b0;
    ce_n = 1'b1;
    si = 1'b0;
  end
  // Sends nb bits MSB first, zeros past 64; keeps the last 64 bits seen.
  // Ten core cycles a half period give the 160 ns serial clock.
  task automatic xfer(input logic [63:0] tx, input int nb,
                      output logic [63:0] rx);
    rx = '0;
    @(negedge clk);
    ce_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      si = (i < 64) ? tx[63 - i] : 1'b0;
      repeat (10) @(negedge clk);
      sck = 1'b1;
      rx = {rx[62:0], so};
      repeat (10) @(negedge clk);
      sck = 1'b0;
    end
    repeat (10) @(negedge clk);
    ce_n = 1'b1;
    si = ~si; // Released line has no pull, so it must not keep its value.
    repeat (10) @(negedge clk);
  endtask
endmodule // fsw_host_model
`default_nettype wire

/* dv/fsw_status_bank_tb_top.sv */
// Self-checking bench for the status and write latch block.
`timescale 1ns/1ns
`default_nettype none
module fsw_status_bank_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  wire sck, ce_n, si, so, so_oe, quad_en, busy;
  wire [7:0] status;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int nv = 0;
  int wlatch = 0;
  int bsy = 0;
  logic [63:0] rx;
  logic [31:0] dw;
  logic [7:0] d;
  // ============================================================
  // Clock, ceiling and instances
  // ============================================================
  // The 125 MHz core clock; a hang ends through the report.
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      summarize();
    end
  end
  fsw_status_bank #(.BUSY_CYCLES(800)) u_fsw_status_bank (.CORE_CLK(clk),
    .SRST(srst), .SCK(sck), .CE_N(ce_n), .SI(si), .SO(so), .SO_OE(so_oe),
    .STATUS(status), .QUAD_EN(quad_en), .BUSY(busy));
  fsw_host_model u_fsw_host_model (.clk(clk), .so(so), .sck(sck),
    .ce_n(ce_n), .si(si));
  // ============================================================
  // Tasks
  // ============================================================
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Reference status built from the model's integers.
  task automatic chk_st();
    chk("status", status, 8'(nv * 4 + wlatch * 2 + bsy));
    chk("quad", {7'h0, quad_en}, 8'((nv >> 4) & 1));
    chk("busy", {7'h0, busy}, 8'(bsy));
  endtask
  task automatic send(input logic [63:0] tx, input int nb);
    u_fsw_host_model.xfer(tx, nb, rx);
  endtask
  // Two whole status bytes must match while the clock keeps running.
  task automatic rd_st();
    send({8'h05, 56'h0}, 24);
    chk("read0", rx[15:8], 8'(nv * 4 + wlatch * 2 + bsy));
    chk("read1", rx[7:0], 8'(nv * 4 + wlatch * 2 + bsy));
    chk("so_oe", {7'h0, so_oe}, 8'h00);
  endtask
  // The latch drops in the same cycle as busy; still allow two more.
  task automatic wait_idle();
    while (busy !== 1'b0) @(negedge clk);
    repeat (2) @(negedge clk);
    bsy = 0;
    wlatch = 0;
  endtask
  // Reset restores the factory cells too, so the stored bits read zero.
  task automatic do_reset();
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    wlatch = 0;
    bsy = 0;
    nv = 0;
  endtask
  task automatic summarize();
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ============================================================
  // Main sequence
  // ============================================================
  initial begin
    void'($urandom(72907));
    do_reset();
    chk_st();
    rd_st();
    send({8'h01, 8'hfc, 48'h0}, 16);
    chk_st();
    send({8'h06, 56'h0}, 8);
    wlatch = 1;
    chk_st();
    send({8'h04, 56'h0}, 8);
    wlatch = 0;
    chk_st();
    // Random status writes; the last keeps the protection field clear.
    for (int k = 0; k < 3; k++) begin
      d = 8'($urandom);
      if (k == 2) d = d & 8'hc3;
      send({8'h06, 56'h0}, 8);
      wlatch = 1;
      send({8'h01, d, 48'h0}, 16);
      nv = d[7:2];
      bsy = 1;
      chk_st();
      send({8'h04, 56'h0}, 8);
      chk_st();
      rd_st();
      wait_idle();
      chk_st();
    end
    send({8'h20, 24'h001000, 32'h0}, 32);
    chk_st();
    send({8'h06, 56'h0}, 8);
    wlatch = 1;
    send({8'h20, 24'h001000, 32'h0}, 32);
    bsy = 1;
    chk_st();
    send({8'h75, 56'h0}, 8);
    bsy = 0;
    chk_st();
    send({8'h7a, 56'h0}, 8);
    bsy = 1;
    chk_st();
    wait_idle();
    chk_st();
    // One protection bit set must block an erase.
    send({8'h06, 56'h0}, 8);
    send({8'h01, 8'h04, 48'h0}, 16);
    nv = 1;
    wait_idle();
    send({8'h06, 56'h0}, 8);
    wlatch = 1;
    send({8'h20, 24'h001000, 32'h0}, 32);
    chk_st();
    do_reset();
    chk_st();
    send({8'h5a, 24'h000064, 8'h0, 24'h0}, 104);
    dw = {rx[39:32], rx[47:40], rx[55:48], rx[63:56]};
    chk("dpd_exit", dw[22:15], 8'hab);
    chk("dpd_enter", dw[30:23], 8'hb9);
    dw = {rx[7:0], rx[15:8], rx[23:16], rx[31:24]};
    chk("quad_off", {4'h0, dw[3:0]}, 8'h0a);
    chk("quad_on", {3'h0, dw[8:4]}, 8'h04);
    summarize();
  end
endmodule // fsw_status_bank_tb_top
`default_nettype wire
